// File: verilog/tgmtx_pkg.sv
package tgmtx_pkg;

    ////////////////////////////////////////////////////////////////////////
    // stream geometry
    localparam int DATA_W = 64;
    localparam int KEEP_W = 8;
    localparam int LEN_W = 12;
    localparam int IDX_W = 8;
    localparam int BUF_DEPTH = 256;
    localparam logic [LEN_W-1:0] BEAT_BYTES = 12'h008;
    localparam logic [LEN_W-1:0] HDR_BYTES = 12'h00e;
    localparam logic [LEN_W-1:0] MIN_FRAME_BYTES = 12'h040;
    localparam logic [IDX_W-1:0] ABORT_MIN_BEAT = 8'h01;
    localparam logic [7:0] PRE_LANE0 = 8'h00;
    localparam logic [KEEP_W-1:0] KEEP_ALL = 8'hff;

    ////////////////////////////////////////////////////////////////////////
    // software register map, byte offsets on the 8-bit command port
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CFG = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_GO = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LEN = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IFG = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_ABORT_AT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PRE_LO = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_PRE_HI = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_WIDX = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_WLO = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_WHI = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h28;

    localparam int CFG_W = 5;
    localparam int PRE_HI_W = 24;
    // reset value of cfg: stream reset held, everything else off
    localparam logic [CFG_W-1:0] CFG_RST = 5'h10;

    typedef enum logic [3:0] {
        SEL_NONE = 4'h0,
        SEL_CFG = 4'h1,
        SEL_GO = 4'h2,
        SEL_LEN = 4'h3,
        SEL_IFG = 4'h4,
        SEL_ABORT_AT = 4'h5,
        SEL_PRE_LO = 4'h6,
        SEL_PRE_HI = 4'h7,
        SEL_WIDX = 4'h8,
        SEL_WLO = 4'h9,
        SEL_WHI = 4'ha,
        SEL_STATUS = 4'hb
    } tgmtx_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PRE = 2'b01,
        ST_DATA = 2'b10
    } tgmtx_state_t;

    // bit 0 custom_pre ... bit 4 mac_rst
    typedef struct packed {
        logic mac_rst;
        logic abort_impl;
        logic abort_expl;
        logic inband_fcs;
        logic custom_pre;
    } tgmtx_cfg_t;

    typedef struct packed {
        logic [DATA_W-1:0] tdata;
        logic [KEEP_W-1:0] tkeep;
        logic tvalid;
        logic tlast;
        logic tuser;
    } tgmtx_axis_t;

    typedef struct packed {
        tgmtx_state_t st;
        logic [IDX_W-1:0] idx;
        logic [LEN_W-1:0] rem;
        logic [IDX_W-1:0] beat;
        logic [7:0] reps;
        tgmtx_axis_t axis;
        logic [31:0] rdata;
        tgmtx_cfg_t cfg;
        logic [LEN_W-1:0] len;
        logic [7:0] ifg;
        logic [IDX_W-1:0] abort_at;
        logic [55:0] pre;
        logic [IDX_W-1:0] widx;
        logic [31:0] wlo;
        logic short_err;
        logic [15:0] sent;
        logic [7:0] aborted;
    } tgmtx_regs_t;

endpackage

// File: verilog/tgmtx_beat.sv
`timescale 1ns/1ps

// lane qualifiers and end flag for a beat holding the next bytes_left bytes
module tgmtx_beat
    import tgmtx_pkg::*;
(
    // byte count still to send, this beat included
    input wire logic [LEN_W-1:0] bytes_left,
    // qualifiers for this beat
    output logic [KEEP_W-1:0] keep,
    output logic last
);

    genvar i;
    generate
        for (i = 0; i < KEEP_W; i++) begin : g_lane
            // lanes beyond the last byte are cleared
            assign keep[i] = (bytes_left > LEN_W'(i));
        end
    endgenerate

    assign last = (bytes_left <= BEAT_BYTES);

endmodule

// File: verilog/tgmtx_client.sv
`timescale 1ns/1ps

module tgmtx_client
    import tgmtx_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // software command port
    input wire logic [ADDR_W-1:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    // transmit stream towards the mac
    output tgmtx_axis_t tx_axis,
    input wire logic axis_tready,
    output logic axis_aresetn,
    output logic [7:0] tx_ifg_delay
);

    ////////////////////////////////////////////////////////////////////////
    // state and frame buffer

    tgmtx_regs_t r_reg;
    tgmtx_regs_t r_next;

    // one frame of up to 2048 bytes; the index wraps beyond that
    logic [DATA_W-1:0] buf_mem [BUF_DEPTH];

    logic [KEEP_W-1:0] first_keep;
    logic first_last;
    logic [KEEP_W-1:0] next_keep;
    logic next_last;
    logic hs;
    logic frame_end;
    logic [IDX_W-1:0] abort_beat;
    tgmtx_sel_t wsel;
    tgmtx_sel_t rsel;

    function automatic tgmtx_sel_t reg_sel(input logic [ADDR_W-1:0] a);
        tgmtx_sel_t s;
        s = SEL_NONE;
        unique case (a)
            OFS_CFG: s = SEL_CFG;
            OFS_GO: s = SEL_GO;
            OFS_LEN: s = SEL_LEN;
            OFS_IFG: s = SEL_IFG;
            OFS_ABORT_AT: s = SEL_ABORT_AT;
            OFS_PRE_LO: s = SEL_PRE_LO;
            OFS_PRE_HI: s = SEL_PRE_HI;
            OFS_WIDX: s = SEL_WIDX;
            OFS_WLO: s = SEL_WLO;
            OFS_WHI: s = SEL_WHI;
            OFS_STATUS: s = SEL_STATUS;
            default: s = SEL_NONE;
        endcase
        return s;
    endfunction

    // bytes remaining after a beat that started with b bytes to go
    function automatic logic [LEN_W-1:0] after_beat(input logic [LEN_W-1:0] b);
        return (b > BEAT_BYTES) ? (b - BEAT_BYTES) : '0;
    endfunction

    assign wsel = sw_wr ? reg_sel(sw_addr) : SEL_NONE;
    assign rsel = sw_rd ? reg_sel(sw_addr) : SEL_NONE;

    ////////////////////////////////////////////////////////////////////////
    // lane qualifiers for the first beat and for a following beat

    tgmtx_beat u_first (
        .bytes_left (r_reg.len),
        .keep (first_keep),
        .last (first_last)
    );

    tgmtx_beat u_next (
        .bytes_left (r_reg.rem),
        .keep (next_keep),
        .last (next_last)
    );

    ////////////////////////////////////////////////////////////////////////
    // buffer fill: the high half completes a word and advances the index

    always_ff @(posedge clk) begin
        if (wsel == SEL_WHI) begin
            buf_mem[r_reg.widx] <= {sw_wdata, r_reg.wlo};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    // an abort never lands before beat 1, so header fields always go out
    assign abort_beat = (r_reg.abort_at < ABORT_MIN_BEAT) ?
                        ABORT_MIN_BEAT : r_reg.abort_at;
    assign hs = r_reg.axis.tvalid && axis_tready;
    assign frame_end = r_reg.axis.tlast ||
                       (r_reg.cfg.abort_impl && r_reg.beat == abort_beat);

    always_comb begin
        r_next = r_reg;
        r_next.rdata = '0;

        // register writes
        unique case (wsel)
            SEL_CFG: r_next.cfg = tgmtx_cfg_t'(sw_wdata[CFG_W-1:0]);
            SEL_LEN: r_next.len = sw_wdata[LEN_W-1:0];
            SEL_IFG: r_next.ifg = sw_wdata[7:0];
            SEL_ABORT_AT: r_next.abort_at = sw_wdata[IDX_W-1:0];
            SEL_PRE_LO: r_next.pre[31:0] = sw_wdata;
            SEL_PRE_HI: r_next.pre[55:32] = sw_wdata[PRE_HI_W-1:0];
            SEL_WIDX: r_next.widx = sw_wdata[IDX_W-1:0];
            SEL_WLO: r_next.wlo = sw_wdata;
            SEL_WHI: r_next.widx = r_reg.widx + 8'h01;
            SEL_STATUS: r_next.short_err = 1'b0;
            default: ;
        endcase

        // register reads, answered in the following cycle only
        unique case (rsel)
            SEL_CFG: r_next.rdata = {27'h0000000, r_reg.cfg};
            SEL_LEN: r_next.rdata = {20'h00000, r_reg.len};
            SEL_IFG: r_next.rdata = {24'h000000, r_reg.ifg};
            SEL_ABORT_AT: r_next.rdata = {24'h000000, r_reg.abort_at};
            SEL_PRE_LO: r_next.rdata = r_reg.pre[31:0];
            SEL_PRE_HI: r_next.rdata = {8'h00, r_reg.pre[55:32]};
            SEL_WIDX: r_next.rdata = {24'h000000, r_reg.widx};
            SEL_WLO: r_next.rdata = r_reg.wlo;
            SEL_STATUS: r_next.rdata = {r_reg.sent, r_reg.aborted,
                                        5'h00, r_reg.st,
                                        r_reg.short_err};
            default: r_next.rdata = '0;
        endcase

        // stream sequencing; a reset request drops valid at its own edge
        if (r_next.cfg.mac_rst) begin
            // nothing may be offered while the mac path is in reset
            r_next.st = ST_IDLE;
            r_next.axis = '0;
        end else begin
            unique case (r_reg.st)
                ST_IDLE: begin
                    if (wsel == SEL_GO) begin
                        if (r_reg.len < HDR_BYTES ||
                            (r_reg.cfg.inband_fcs &&
                             r_reg.len < MIN_FRAME_BYTES)) begin
                            // the mac will not pad in-band frames
                            r_next.short_err = 1'b1;
                        end else begin
                            r_next.reps = (sw_wdata[7:0] == 8'h00) ?
                                          8'h01 : sw_wdata[7:0];
                            r_next.axis.tvalid = 1'b1;
                            if (r_reg.cfg.custom_pre) begin
                                r_next.st = ST_PRE;
                                r_next.axis.tdata = {r_reg.pre,
                                                     PRE_LANE0};
                                r_next.axis.tkeep = KEEP_ALL;
                                r_next.axis.tlast = 1'b0;
                                r_next.axis.tuser = 1'b0;
                            end else begin
                                r_next.st = ST_DATA;
                                r_next.idx = 8'h01;
                                r_next.beat = '0;
                                r_next.rem = after_beat(r_reg.len);
                                r_next.axis.tdata = buf_mem[8'h00];
                                r_next.axis.tkeep = first_keep;
                                r_next.axis.tlast = first_last;
                                r_next.axis.tuser = 1'b0;
                            end
                        end
                    end
                end
                ST_PRE: begin
                    // custom preamble word accepted: first data word next
                    if (hs) begin
                        r_next.st = ST_DATA;
                        r_next.idx = 8'h01;
                        r_next.beat = '0;
                        r_next.rem = after_beat(r_reg.len);
                        r_next.axis.tdata = buf_mem[8'h00];
                        r_next.axis.tkeep = first_keep;
                        r_next.axis.tlast = first_last;
                        r_next.axis.tuser = 1'b0;
                    end
                end
                ST_DATA: begin
                    // without a handshake the beat simply stands
                    if (hs && frame_end) begin
                        r_next.sent = r_reg.sent + 16'h0001;
                        if (r_reg.axis.tuser || !r_reg.axis.tlast) begin
                            // counted only; resubmission is up to software
                            r_next.aborted = r_reg.aborted + 8'h01;
                        end
                        // an implicit abort must show as valid low
                        if (r_reg.reps > 8'h01 && r_reg.axis.tlast) begin
                            // valid stays high into the next copy
                            r_next.reps = r_reg.reps - 8'h01;
                            r_next.axis.tuser = 1'b0;
                            if (r_reg.cfg.custom_pre) begin
                                r_next.st = ST_PRE;
                                r_next.axis.tdata = {r_reg.pre, PRE_LANE0};
                                r_next.axis.tkeep = KEEP_ALL;
                                r_next.axis.tlast = 1'b0;
                            end else begin
                                r_next.idx = 8'h01;
                                r_next.beat = '0;
                                r_next.rem = after_beat(r_reg.len);
                                r_next.axis.tdata = buf_mem[8'h00];
                                r_next.axis.tkeep = first_keep;
                                r_next.axis.tlast = first_last;
                            end
                        end else begin
                            // implicit abort shows here as valid dropping
                            r_next.st = ST_IDLE;
                            r_next.axis = '0;
                        end
                    end else if (hs) begin
                        r_next.idx = r_reg.idx + 8'h01;
                        r_next.beat = r_reg.beat + 8'h01;
                        r_next.rem = after_beat(r_reg.rem);
                        r_next.axis.tdata = buf_mem[r_reg.idx];
                        r_next.axis.tkeep = next_keep;
                        r_next.axis.tlast = next_last;
                        r_next.axis.tuser = 1'b0;
                        if (r_reg.cfg.abort_expl &&
                            r_reg.beat + 8'h01 == abort_beat) begin
                            // underrun marks the beat and closes the frame
                            r_next.axis.tuser = 1'b1;
                            r_next.axis.tlast = 1'b1;
                        end else if (r_reg.cfg.abort_impl &&
                                     r_reg.beat + 8'h01 == abort_beat) begin
                            r_next.axis.tlast = 1'b0;
                        end
                    end
                end
                default: begin
                    r_next.st = ST_IDLE;
                    r_next.axis = '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r_reg <= '{st: ST_IDLE, cfg: tgmtx_cfg_t'(CFG_RST), default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign sw_rdata = r_reg.rdata;
    assign tx_axis = r_reg.axis;
    assign axis_aresetn = !r_reg.cfg.mac_rst;
    assign tx_ifg_delay = r_reg.ifg;

endmodule

// File: sim/tgmtx_mac_model.sv
`timescale 1ns/1ps

// mac end of the stream: stalls for the gap, tallies frames and errors
module tgmtx_mac_model
    import tgmtx_pkg::*;
(
    // clock and stream reset
    input wire logic clk,
    input wire logic axis_aresetn,
    // stream
    input wire tgmtx_axis_t tx_axis,
    input wire logic [7:0] tx_ifg_delay,
    input wire logic slow,
    output logic axis_tready,
    // tallies
    output int nframes,
    output int nerr
);
    int gap;
    logic in_frame;
    logic phase = 1'b0;

    // slow mode drops ready every other cycle to exercise held beats
    assign axis_tready = axis_aresetn && gap == 0 && (!slow || phase);

    // gap columns are counted as whole cycles, erring on the slow side
    always @(posedge clk) begin
        phase <= !phase;
        if (!axis_aresetn) begin
            gap <= 0;
            in_frame <= 1'b0;
        end else if (tx_axis.tvalid && axis_tready) begin
            in_frame <= !tx_axis.tlast;
            if (tx_axis.tlast) begin
                nframes <= nframes + 1;
                gap <= (tx_ifg_delay < 8'h03) ? 3 : int'(tx_ifg_delay);
            end
            if (tx_axis.tuser) nerr <= nerr + 1;
        end else begin
            if (gap > 0) gap <= gap - 1;
            if (in_frame && !tx_axis.tvalid) begin
                nerr <= nerr + 1;
                nframes <= nframes + 1;
                in_frame <= 1'b0;
            end
        end
    end
endmodule

// File: sim/tgmtx_client_sva.sv
`timescale 1ns/1ps

module tgmtx_client_sva
    import tgmtx_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // command port
    input wire logic [ADDR_W-1:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    input wire logic [31:0] sw_rdata,
    // stream
    input wire tgmtx_axis_t tx_axis,
    input wire logic axis_tready,
    input wire logic axis_aresetn,
    input wire logic [7:0] tx_ifg_delay
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic acc = tx_axis.tvalid && axis_tready;

    hold_beat_a: assert property (tx_axis.tvalid && !axis_tready |=>
        $stable(tx_axis)) else $error("stalled beat changed");
    single_last_a: assert property (acc && tx_axis.tlast |=>
        !(tx_axis.tvalid && tx_axis.tlast)) else $error("end flag repeated");
    full_keep_a: assert property (tx_axis.tvalid && !tx_axis.tlast |->
        tx_axis.tkeep == KEEP_ALL) else $error("partial inner beat");
    last_keep_a: assert property (tx_axis.tvalid && tx_axis.tlast |->
        tx_axis.tkeep[0] && ((tx_axis.tkeep + 8'h01) & tx_axis.tkeep) == 8'h00)
        else $error("final lanes not packed low");
    abort_end_a: assert property (tx_axis.tvalid && tx_axis.tuser |->
        tx_axis.tlast) else $error("underrun without end flag");
    mac_idle_a: assert property (!axis_aresetn |-> !tx_axis.tvalid)
        else $error("valid while mac in reset");
    mac_rst_a: assert property (sw_wr && sw_addr == OFS_CFG |=>
        axis_aresetn == !$past(sw_wdata[4])) else $error("mac reset wrong");
    ifg_drive_a: assert property (sw_wr && sw_addr == OFS_IFG |=>
        tx_ifg_delay == $past(sw_wdata[7:0])) else $error("gap value wrong");
    rd_quiet_a: assert property (!sw_rd |=> sw_rdata == 32'h0)
        else $error("read data outside read slot");

    cover property (acc && tx_axis.tlast);
    cover property (acc && tx_axis.tuser);
    cover property (tx_axis.tvalid && !axis_tready);
endmodule

bind tgmtx_client tgmtx_client_sva u_tgmtx_client_sva (.clk(clk),
    .rstn(rstn), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .tx_axis(tx_axis),
    .axis_tready(axis_tready), .axis_aresetn(axis_aresetn),
    .tx_ifg_delay(tx_ifg_delay));

// File: sim/tb_tgmtx_client.sv
`timescale 1ns/1ps

module tb_tgmtx_client
    import tgmtx_pkg::*;
;
    logic clk, rstn, sw_wr, sw_rd, axis_tready, axis_aresetn, slow;
    logic [ADDR_W-1:0] sw_addr;
    logic [31:0] sw_wdata, sw_rdata;
    logic [7:0] tx_ifg_delay;
    tgmtx_axis_t tx_axis;
    tgmtx_axis_t seen[$];
    int nframes, nerr, mismatches, checked, nsent, nab;

    tgmtx_client u_tgmtx_client (.clk(clk), .rstn(rstn), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .tx_axis(tx_axis), .axis_tready(axis_tready),
        .axis_aresetn(axis_aresetn), .tx_ifg_delay(tx_ifg_delay));
    tgmtx_mac_model u_tgmtx_mac_model (.clk(clk),
        .axis_aresetn(axis_aresetn), .tx_axis(tx_axis),
        .tx_ifg_delay(tx_ifg_delay), .slow(slow), .axis_tready(axis_tready),
        .nframes(nframes), .nerr(nerr));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rstn && tx_axis.tvalid && axis_tready) seen.push_back(tx_axis);
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] e,
                       input logic [63:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string what);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        @(negedge clk);
        chk(what, {32'h0, e}, {32'h0, sw_rdata});
        @(posedge clk);
    endtask
    task automatic stat(input logic short);
        rd(OFS_STATUS, {16'(nsent), 8'(nab), 7'h0, short}, "status");
        chk("mac frames", 64'(nsent), 64'(nframes));
        chk("mac errors", 64'(nab), 64'(nerr));
    endtask
    function automatic logic [7:0] fb(input int j);
        return 8'(j) ^ 8'ha5;
    endfunction
    task automatic load(input int len);
        logic [63:0] w;
        wr(OFS_WIDX, 32'h0);
        for (int k = 0; k < (len + 7) / 8; k++) begin
            for (int i = 0; i < 8; i++) w[8*i+:8] = fb(8 * k + i);
            wr(OFS_WLO, w[31:0]);
            wr(OFS_WHI, w[63:32]);
        end
        wr(OFS_LEN, 32'(len));
    endtask

    // ab is the data beat that carries the abort, 0 for none
    task automatic run(input int len, input int reps, input bit pre,
                       input int ab, input bit expl);
        int n, m, idx, tot;
        logic [63:0] d, msk;
        logic [7:0] kp;
        n = (len + 7) / 8;
        m = (ab > 0) ? ab + 1 : n;
        tot = reps * (m + int'(pre));
        seen.delete();
        load(len);
        wr(OFS_GO, 32'(reps));
        for (int t = 0; t < 4000 && seen.size() < tot; t++) @(posedge clk);
        if (seen.size() < tot) begin
            mismatches++;
            $display("CHECK FAILED beats expected %0d seen %0d", tot,
                     seen.size());
            summarize();
        end
        repeat (40) @(posedge clk);
        chk("beat count", 64'(tot), 64'(seen.size()));
        idx = 0;
        for (int r = 0; r < reps; r++) begin
            if (pre) begin
                chk("preamble", {56'h77665544332211, PRE_LANE0},
                    seen[idx].tdata);
                idx++;
            end
            for (int k = 0; k < m; k++) begin
                kp = (k == n - 1 && len % 8 != 0) ? 8'hff >> (8 - len % 8)
                                                   : KEEP_ALL;
                for (int i = 0; i < 8; i++) begin
                    d[8*i+:8] = fb(8 * k + i);
                    msk[8*i+:8] = {8{kp[i]}};
                end
                chk("data", d & msk, seen[idx].tdata & msk);
                chk("keep", 64'(kp), 64'(seen[idx].tkeep));
                chk("last", 64'(k == m - 1 && (ab == 0 || expl)),
                    64'(seen[idx].tlast));
                chk("underrun", 64'(k == m - 1 && ab > 0 && expl),
                    64'(seen[idx].tuser));
                idx++;
            end
        end
        nsent += reps;
        nab += (ab > 0) ? reps : 0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("mac reset", 64'h0, 64'(axis_aresetn));
        rd(OFS_CFG, 32'(CFG_RST), "cfg");
        rd(8'h30, 32'h0, "unmapped");
        load(16);
        wr(OFS_GO, 32'h1);
        repeat (4) @(posedge clk);
        chk("held idle", 64'h0, 64'(tx_axis.tvalid));
        stat(1'b0);
        rd(OFS_LEN, 32'h10, "len");
        rd(OFS_WIDX, 32'h2, "widx");
        rd(OFS_WLO, 32'haeafacad, "wlo");
        rd(OFS_GO, 32'h0, "go");
        wr(OFS_CFG, 32'h0);
        chk("mac run", 64'h1, 64'(axis_aresetn));
        wr(OFS_IFG, 32'h4);
        chk("gap", 64'h4, 64'(tx_ifg_delay));
        rd(OFS_IFG, 32'h4, "ifg");
        $display("test reset done");
    endtask
    task automatic t_plain();
        run(20, 1, 1'b0, 0, 1'b0);
        run(14, 1, 1'b0, 0, 1'b0);
        run(1530, 1, 1'b0, 0, 1'b0);
        stat(1'b0);
        $display("test plain done");
    endtask
    task automatic t_b2b();
        slow <= 1'b1;
        run(64, 3, 1'b0, 0, 1'b0);
        slow <= 1'b0;
        stat(1'b0);
        $display("test back to back done");
    endtask
    task automatic t_pre();
        wr(OFS_PRE_LO, 32'h44332211);
        wr(OFS_PRE_HI, 32'h00776655);
        rd(OFS_PRE_LO, 32'h44332211, "pre lo");
        rd(OFS_PRE_HI, 32'h00776655, "pre hi");
        wr(OFS_CFG, 32'h1);
        run(24, 2, 1'b1, 0, 1'b0);
        wr(OFS_CFG, 32'h0);
        $display("test preamble done");
    endtask
    task automatic t_abort();
        wr(OFS_CFG, 32'h4);
        wr(OFS_ABORT_AT, 32'h1);
        rd(OFS_ABORT_AT, 32'h1, "abort at");
        run(40, 1, 1'b0, 1, 1'b1);
        wr(OFS_CFG, 32'h8);
        wr(OFS_ABORT_AT, 32'h0);
        run(40, 1, 1'b0, 1, 1'b0);
        wr(OFS_CFG, 32'h0);
        run(24, 1, 1'b0, 0, 1'b0);
        stat(1'b0);
        $display("test abort done");
    endtask
    task automatic t_refuse();
        wr(OFS_CFG, 32'h2);
        seen.delete();
        load(60);
        wr(OFS_GO, 32'h1);
        repeat (10) @(posedge clk);
        chk("refused beats", 64'h0, 64'(seen.size()));
        stat(1'b1);
        run(64, 1, 1'b0, 0, 1'b0);
        wr(OFS_STATUS, 32'h0);
        stat(1'b0);
        wr(OFS_CFG, 32'h0);
        load(13);
        wr(OFS_GO, 32'h1);
        stat(1'b1);
        $display("test refuse done");
    endtask

    initial begin
        rstn = 1'b0;
        sw_addr = '0;
        sw_wdata = '0;
        sw_wr = 1'b0;
        sw_rd = 1'b0;
        slow = 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_plain();
        t_b2b();
        t_pre();
        t_abort();
        t_refuse();
        summarize();
    end
endmodule
